// ===== bench/clk_board_model.sv
`timescale 1ns/10ps
`default_nettype none

module clk_board_model #(
    parameter int LOCK_DLY = 40
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // scenario control
    input  wire logic [2:0] cfg_i,
    input  wire logic       mem_drop_i,
    // straps
    output logic            src_o,
    output logic            type_o,
    output logic            ratio_o,
    // multiplier locks
    output logic            sys_lock_o,
    output logic            mem_lock_o,
    output logic            link_lock_o
);
    logic [7:0] cnt_q;
    logic       locked;

    // straps follow the board setting, moved by the bench in reset and once after capture
    assign {ratio_o, type_o, src_o} = cfg_i;

    // multipliers lock a while after reset release
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 8'h00;
        end else if (!locked) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign locked      = (cnt_q == 8'(LOCK_DLY));
    assign sys_lock_o  = locked;
    assign mem_lock_o  = locked && !mem_drop_i;
    assign link_lock_o = locked;
endmodule // clk_board_model

`default_nettype wire

// ===== bench/memory_system_clock_select_test.sv
`timescale 1ns/10ps
`default_nettype none

module memory_system_clock_select_test
    import clk_sel_pkg::*;
;
    typedef struct packed {
        logic [MULT_W-1:0] sys;
        logic [MULT_W-1:0] mem;
        logic [MUXS_W-1:0] mux;
        logic [3:0]        bits; // sys mux, alt, bypass, ddr2
    } row_t;

    logic              clk, rst_b, mem_drop;
    logic [2:0]        cfg;
    logic              src, mtype, ratio, sys_lock, mem_lock, link_lock;
    logic [MULT_W-1:0] sys_mult, mem_mult, link_mult;
    logic [MUXS_W-1:0] mem_mux;
    logic              sys_mux, alt, bypass, ddr2, sys_en, mem_en, link_en, cfg_valid;
    int                error_cnt, checks;

    // row index is the strap setting {ratio, type, source}
    row_t rows [8] = '{
        '{MULT_X4, MULT_X6, MUX_REF_X6, 4'h1}, '{MULT_X4, MULT_X3, MUX_ALT_X3, 4'h5},
        '{MULT_X4, MULT_X2, MUX_REF_X2, 4'h0}, '{MULT_X4, MULT_X1, MUX_ALT_DIR, 4'h6},
        '{MULT_X3, MULT_X6, MUX_REF_X6, 4'h9}, '{MULT_X3, MULT_X3, MUX_ALT_X3, 4'hD},
        '{MULT_X3, MULT_X1P5, MUX_REF_X1P5, 4'h8}, '{MULT_X3, MULT_X1, MUX_ALT_DIR, 4'hE}};

    clk_select u_dut (
        .CLK_I(clk), .RST_B_I(rst_b),
        .MEM_CLK_SRC_SEL_I(src), .MEM_TYPE_SEL_I(mtype), .FREQ_RATIO_SEL_I(ratio),
        .SYS_LOCK_I(sys_lock), .MEM_LOCK_I(mem_lock), .LINK_LOCK_I(link_lock),
        .SYS_MULT_O(sys_mult), .MEM_MULT_O(mem_mult), .LINK_MULT_O(link_mult),
        .SYS_MUX_SEL_O(sys_mux), .MEM_MUX_SEL_O(mem_mux), .MEM_SRC_ALT_O(alt),
        .MEM_BYPASS_O(bypass), .MEM_DDR2_O(ddr2), .SYS_CLK_EN_O(sys_en),
        .MEM_CLK_EN_O(mem_en), .LINK_CLK_EN_O(link_en), .CFG_VALID_O(cfg_valid)
    );

    clk_board_model u_board (
        .clk_i(clk), .rst_b_i(rst_b), .cfg_i(cfg), .mem_drop_i(mem_drop),
        .src_o(src), .type_o(mtype), .ratio_o(ratio),
        .sys_lock_o(sys_lock), .mem_lock_o(mem_lock), .link_lock_o(link_lock)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d, error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // bounded wait on valid (sel 0) or system enable (sel 1)
    task automatic wait_hi(input int sel, input int lim);
        int n;
        n = 0;
        while (((sel == 0) ? cfg_valid : sys_en) !== 1'b1) begin
            if (n == lim) begin
                error_cnt++;
                $display("unexpected timeout on wait %0d", sel);
                close_out();
            end
            n++;
            @(negedge clk);
        end
    endtask

    task automatic do_reset(input logic [2:0] c);
        @(negedge clk);
        rst_b = 1'b0;
        cfg   = c;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
    endtask

    initial begin
        error_cnt = 0;
        checks    = 0;
        rst_b     = 1'b0;
        cfg       = 3'h7;
        mem_drop  = 1'b0;
        repeat (12) @(negedge clk);
        // defaults while held in reset
        check("sys mult", sys_mult, MULT_X4);
        check("mem mult", mem_mult, MULT_X6);
        check("ddr2", 4'(ddr2), 4'h1);
        check("cfg valid", 4'(cfg_valid), 4'h0);
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            do_reset(3'(i));
            wait_hi(0, 20);
            repeat (2) @(negedge clk);
            check("sys mult", sys_mult, rows[i].sys);
            check("mem mult", mem_mult, rows[i].mem);
            check("mem mux", {1'b0, mem_mux}, {1'b0, rows[i].mux});
            check("sys mux", 4'(sys_mux), 4'(rows[i].bits[3]));
            check("alt src", 4'(alt), 4'(rows[i].bits[2]));
            check("bypass", 4'(bypass), 4'(rows[i].bits[1]));
            check("ddr2", 4'(ddr2), 4'(rows[i].bits[0]));
            check("link mult", link_mult, MULT_LINK);
            check("sys en early", 4'(sys_en), 4'h0);
        end
        // strap moves after capture are ignored
        cfg = 3'h0;
        wait_hi(1, 3000);
        check("mem en", 4'(mem_en), 4'h1);
        check("link en", 4'(link_en), 4'h1);
        check("mem mult kept", mem_mult, MULT_X1);
        check("sys mult kept", sys_mult, MULT_X3);
        mem_drop = 1'b1;
        repeat (8) @(negedge clk);
        check("mem en drop", 4'(mem_en), 4'h0);
        check("sys en kept", 4'(sys_en), 4'h1);
        mem_drop = 1'b0;
        repeat (8) @(negedge clk);
        check("mem en back", 4'(mem_en), 4'h1);
        close_out();
    end
endmodule // memory_system_clock_select_test

`default_nettype wire

// ===== core/clk_sel_pkg.sv
package clk_sel_pkg;

    // reference clock of this logic
    localparam int CLK_FREQ_MHZ = 25;

    // multiplier settle time, in ns, and its cycle count (rounded up)
    localparam int SETTLE_TIME_NS = 100_000;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

    // cycles spent after reset before straps are captured
    localparam int SAMPLE_CYCLES = 4;

    localparam int CNT_W   = 12;
    localparam int MULT_W  = 4;
    localparam int MUXS_W  = 3;
    localparam int SYNC_W  = 6;

    // strap and lock positions in the synchronised vector
    localparam int BIT_SRC      = 0;
    localparam int BIT_TYPE     = 1;
    localparam int BIT_RATIO    = 2;
    localparam int BIT_SYS_LOCK = 3;
    localparam int BIT_MEM_LOCK = 4;
    localparam int BIT_LNK_LOCK = 5;

    // multiplier factors in half steps (value = 2 x factor)
    localparam logic [MULT_W-1:0] MULT_X1   = 4'h2;
    localparam logic [MULT_W-1:0] MULT_X1P5 = 4'h3;
    localparam logic [MULT_W-1:0] MULT_X2   = 4'h4;
    localparam logic [MULT_W-1:0] MULT_X3   = 4'h6;
    localparam logic [MULT_W-1:0] MULT_X4   = 4'h8;
    localparam logic [MULT_W-1:0] MULT_X6   = 4'hC;
    localparam logic [MULT_W-1:0] MULT_LINK = MULT_X4;

    // memory clock multiplexer paths
    localparam logic [MUXS_W-1:0] MUX_REF_X6   = 3'h0;
    localparam logic [MUXS_W-1:0] MUX_REF_X2   = 3'h1;
    localparam logic [MUXS_W-1:0] MUX_REF_X1P5 = 3'h2;
    localparam logic [MUXS_W-1:0] MUX_ALT_X3   = 3'h3;
    localparam logic [MUXS_W-1:0] MUX_ALT_DIR  = 3'h4;

    // system clock multiplexer paths
    localparam logic SYS_MUX_X4 = 1'b0;
    localparam logic SYS_MUX_X3 = 1'b1;

    typedef enum logic [1:0] {ST_SAMPLE, ST_SETTLE, ST_RUN} seq_state_t;

    function automatic logic [MULT_W-1:0] sys_mult(input logic ratio);
        sys_mult = ratio ? MULT_X3 : MULT_X4;
    endfunction

    function automatic logic [MULT_W-1:0] mem_mult(input logic src, input logic sdr,
                                                   input logic ratio);
        if (!src && !sdr) begin
            mem_mult = MULT_X6;
        end else if (!src) begin
            mem_mult = ratio ? MULT_X1P5 : MULT_X2;
        end else if (!sdr) begin
            mem_mult = MULT_X3;
        end else begin
            mem_mult = MULT_X1;
        end
    endfunction

    function automatic logic [MUXS_W-1:0] mem_path(input logic src, input logic sdr,
                                                   input logic ratio);
        if (!src && !sdr) begin
            mem_path = MUX_REF_X6;
        end else if (!src) begin
            mem_path = ratio ? MUX_REF_X1P5 : MUX_REF_X2;
        end else if (!sdr) begin
            mem_path = MUX_ALT_X3;
        end else begin
            mem_path = MUX_ALT_DIR;
        end
    endfunction

endpackage

// ===== core/clk_select.sv
// Operation
// RULE1: one system clock enable drives every processor, bus and core.
// RULE2: source strap low picks reference clock, high picks alternate memory clock.
// RULE3: system multiplier 4x when ratio strap low, 3x when high; nothing else.
// RULE4: type strap low runs DDR2 memory mode, high runs SDR SDRAM mode.
// RULE5: reference source with DDR2 gives memory clock 6x reference.
// RULE6: reference source with SDR gives 2x, or 1.5x when ratio strap high.
// RULE7: alternate source with DDR2 gives memory clock 3x alternate input.
// RULE8: alternate source with SDR passes alternate input straight through.
// RULE9: system and memory clocks each leave through a multiplexer select.
// RULE10: system, memory and link clocks come from on-chip multipliers.
// RULE11: link clock multiplier factor defaults to four.
// RULE12: board keeps straps stable from before reset; captured once, held static.
`timescale 1ns/10ps
`default_nettype none

module clk_select
    import clk_sel_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RST_B_I,
    // board straps
    input  wire logic              MEM_CLK_SRC_SEL_I,
    input  wire logic              MEM_TYPE_SEL_I,
    input  wire logic              FREQ_RATIO_SEL_I,
    // multiplier lock indications
    input  wire logic              SYS_LOCK_I,
    input  wire logic              MEM_LOCK_I,
    input  wire logic              LINK_LOCK_I,
    // multiplier settings
    output logic      [MULT_W-1:0] SYS_MULT_O,
    output logic      [MULT_W-1:0] MEM_MULT_O,
    output logic      [MULT_W-1:0] LINK_MULT_O,
    // multiplexer selects
    output logic                   SYS_MUX_SEL_O,
    output logic      [MUXS_W-1:0] MEM_MUX_SEL_O,
    output logic                   MEM_SRC_ALT_O,
    output logic                   MEM_BYPASS_O,
    // memory mode
    output logic                   MEM_DDR2_O,
    // clock enables and status
    output logic                   SYS_CLK_EN_O,
    output logic                   MEM_CLK_EN_O,
    output logic                   LINK_CLK_EN_O,
    output logic                   CFG_VALID_O
);

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_lvl;
    seq_state_t        seq_q;
    seq_state_t        seq_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic              src_q;
    logic              sdr_q;
    logic              ratio_q;
    logic              sample_done;
    logic              settle_done;
    logic              all_locked;
    logic              capture;
    logic              run_d;

    assign sync_in = {LINK_LOCK_I, MEM_LOCK_I, SYS_LOCK_I,
                      FREQ_RATIO_SEL_I, MEM_TYPE_SEL_I, MEM_CLK_SRC_SEL_I};

    level_sync #(.W(SYNC_W)) u_sync (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .async_i (sync_in),
        .level_o (sync_lvl)
    );

    // sequencing: sample straps, wait for multipliers, run
    // synchronised straps settle at the fourth edge, so capture one edge later
    assign sample_done = (cnt_q == CNT_W'(SAMPLE_CYCLES));
    assign settle_done = (cnt_q == CNT_W'(SETTLE_CYCLES - 1));
    assign all_locked  = sync_lvl[BIT_SYS_LOCK] & sync_lvl[BIT_MEM_LOCK]
                       & sync_lvl[BIT_LNK_LOCK];
    assign capture     = (seq_q == ST_SAMPLE) && sample_done;  // see RULE12
    assign run_d       = (seq_d == ST_RUN);

    always_comb begin
        seq_d = seq_q;
        cnt_d = cnt_q;
        case (seq_q)
            ST_SAMPLE: begin
                cnt_d = cnt_q + CNT_W'(1);
                if (sample_done) begin
                    seq_d = ST_SETTLE;
                    cnt_d = '0;
                end
            end
            ST_SETTLE: begin
                if (!settle_done) begin
                    cnt_d = cnt_q + CNT_W'(1);
                end else if (all_locked) begin
                    seq_d = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_d = cnt_q;
            end
            default: begin
                seq_d = ST_SAMPLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            seq_q <= ST_SAMPLE;
            cnt_q <= '0;
        end else begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
        end
    end

    // strap capture, held static afterwards
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            src_q   <= 1'b0;
            sdr_q   <= 1'b0;
            ratio_q <= 1'b0;
        end else if (capture) begin  // see RULE12
            src_q   <= sync_lvl[BIT_SRC];
            sdr_q   <= sync_lvl[BIT_TYPE];
            ratio_q <= sync_lvl[BIT_RATIO];
        end
    end

    // multiplier and multiplexer settings
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SYS_MULT_O    <= MULT_X4;
            MEM_MULT_O    <= MULT_X6;
            LINK_MULT_O   <= MULT_LINK;
            SYS_MUX_SEL_O <= SYS_MUX_X4;
            MEM_MUX_SEL_O <= MUX_REF_X6;
            MEM_SRC_ALT_O <= 1'b0;
            MEM_BYPASS_O  <= 1'b0;
            MEM_DDR2_O    <= 1'b1;
        end else begin
            SYS_MULT_O    <= sys_mult(ratio_q);                    // see RULE3 see RULE10
            MEM_MULT_O    <= mem_mult(src_q, sdr_q, ratio_q);      // see RULE5 see RULE6
            LINK_MULT_O   <= MULT_LINK;                            // see RULE11
            SYS_MUX_SEL_O <= ratio_q ? SYS_MUX_X3 : SYS_MUX_X4;    // see RULE9
            MEM_MUX_SEL_O <= mem_path(src_q, sdr_q, ratio_q);      // see RULE7 see RULE9
            MEM_SRC_ALT_O <= src_q;                                // see RULE2
            MEM_BYPASS_O  <= src_q & sdr_q;                        // see RULE8
            MEM_DDR2_O    <= ~sdr_q;                               // see RULE4
        end
    end

    // clock enables, only once multipliers have locked
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SYS_CLK_EN_O  <= 1'b0;
            MEM_CLK_EN_O  <= 1'b0;
            LINK_CLK_EN_O <= 1'b0;
            CFG_VALID_O   <= 1'b0;
        end else begin
            SYS_CLK_EN_O  <= run_d & sync_lvl[BIT_SYS_LOCK];  // see RULE1 see RULE10
            MEM_CLK_EN_O  <= run_d & sync_lvl[BIT_MEM_LOCK];  // see RULE10
            LINK_CLK_EN_O <= run_d & sync_lvl[BIT_LNK_LOCK];  // see RULE10
            CFG_VALID_O   <= (seq_q != ST_SAMPLE);
        end
    end

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    a_sys_mult_ratio: assert property (CFG_VALID_O |-> ##1 // see RULE3
        SYS_MULT_O == ($past(ratio_q) ? MULT_X3 : MULT_X4))
        else $error("system multiplier does not follow ratio strap");

    a_mem_ref_ddr2: assert property ((CFG_VALID_O && !src_q && !sdr_q) |=> // see RULE5
        MEM_MULT_O == MULT_X6 && MEM_MUX_SEL_O == MUX_REF_X6)
        else $error("reference DDR2 memory clock not 6x");

    a_mem_ref_sdr: assert property ((CFG_VALID_O && !src_q && sdr_q) |=> // see RULE6
        MEM_MULT_O == ($past(ratio_q) ? MULT_X1P5 : MULT_X2))
        else $error("reference SDR memory clock wrong");

    a_mem_alt_ddr2: assert property ((CFG_VALID_O && src_q && !sdr_q) |=> // see RULE7
        MEM_MULT_O == MULT_X3 && MEM_MUX_SEL_O == MUX_ALT_X3)
        else $error("alternate DDR2 memory clock not 3x");

    a_mem_alt_pass: assert property ((CFG_VALID_O && src_q && sdr_q) |=> // see RULE8
        MEM_BYPASS_O && MEM_MUX_SEL_O == MUX_ALT_DIR && MEM_MULT_O == MULT_X1)
        else $error("alternate SDR memory clock not passed through");

    a_src_follow: assert property (CFG_VALID_O |=> MEM_SRC_ALT_O == $past(src_q)) // see RULE2
        else $error("memory clock source does not follow strap");

    a_type_follow: assert property (CFG_VALID_O |=> MEM_DDR2_O != $past(sdr_q)) // see RULE4
        else $error("memory type does not follow strap");

    a_straps_static: assert property ((seq_q != ST_SAMPLE) |=> // see RULE12
        $stable(src_q) && $stable(sdr_q) && $stable(ratio_q))
        else $error("captured straps changed after capture");

    a_link_mult: assert property (##1 LINK_MULT_O == MULT_X4) // see RULE11
        else $error("link multiplier not four");

    a_en_needs_lock: assert property (SYS_CLK_EN_O |-> $past(sync_lvl[BIT_SYS_LOCK])) // see RULE10
        else $error("system clock enabled without lock");

    a_en_after_settle: assert property ($rose(SYS_CLK_EN_O) |-> // see RULE1
        $past(seq_q) != ST_SAMPLE && CFG_VALID_O)
        else $error("system clock enabled before settle");

    c_ref_ddr2_run: cover property (SYS_CLK_EN_O && !src_q && !sdr_q);
    c_alt_sdr_run:  cover property (SYS_CLK_EN_O && MEM_BYPASS_O);
    c_ratio_high:   cover property (MEM_CLK_EN_O && SYS_MULT_O == MULT_X3);
    c_lock_loss:    cover property ($fell(MEM_CLK_EN_O));

endmodule // clk_select

`default_nettype wire

// ===== core/level_sync.sv
`timescale 1ns/10ps
`default_nettype none

module level_sync
    import clk_sel_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] agree;
    logic [W-1:0] level_d;

    assign agree   = ~(ff2_q ^ ff3_q);
    assign level_d = (agree & ff3_q) | (~agree & level_o);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ff1_q   <= '0;
            ff2_q   <= '0;
            ff3_q   <= '0;
            level_o <= '0;
        end else begin
            ff1_q   <= async_i;
            ff2_q   <= ff1_q;
            ff3_q   <= ff2_q;
            level_o <= level_d;
        end
    end

endmodule // level_sync

`default_nettype wire
